// ==== src/pae_evaluator.sv ====
// process alarm evaluator: three alarms with hysteresis, standby, latch and polarity
// assumes an APB master on clk, process_value synchronous to clk, power_ok from a pin
`timescale 1ns/100ps
`include "pae_regs.svh"
module pae_evaluator
    import pae_pkg::*;
#(
    parameter int NALM = 3,
    parameter int NBANK = 4,
    parameter int HOLD_CYCLES = `PAE_HOLD_TIME_MS * `PAE_CLK_KHZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] process_value,
    input wire logic power_ok,
    output logic [NALM-1:0] alarm_out
);
    localparam int CW = 22;
    localparam int HCW = $clog2(HOLD_CYCLES + 1);

    // refuse shapes the address map or the counters cannot serve
    if (NALM < 1 || NALM > 4 || NBANK < 1 || NBANK > 4 || HOLD_CYCLES < 1) begin : g_chk
        $error("pae_evaluator: unsupported parameter values");
    end

    typedef struct packed {
        logic [1:0] pok;
        logic [HCW-1:0] hold_cnt;
        logic run;
        logic [1:0] dp;
        logic [15:0] set_point;
        logic [15:0] in_shift;
        logic [1:0] bank;
        logic [NALM-1:0][3:0] typ;
        logic [NALM-1:0] latch_en;
        logic [NALM-1:0] open_en;
        logic [NALM-1:0] assigned;
        logic [NALM-1:0][13:0] hyst;
        logic [NBANK-1:0][NALM-1:0][2:0][15:0] val;
        logic [NALM-1:0] raw;
        logic [NALM-1:0] armed;
        logic [NALM-1:0] latched;
        logic [NALM-1:0] fst;
        logic [NALM-1:0] out;
        logic [31:0] prdata;
        logic pslverr;
    } pae_st_s;

    pae_st_s st_r;
    pae_st_s st_nxt;

    // sign-extend a 16-bit setting to the compare width
    function automatic logic signed [CW-1:0] pae_ext(input logic [15:0] v);
        pae_ext = CW'($signed(v));
    endfunction : pae_ext

    // decimal point 0 puts hysteresis in tenths, so values go to tenths too
    function automatic logic signed [CW-1:0] pae_scl(input logic signed [CW-1:0] e,
                                                     input logic ten);
        pae_scl = ten ? (e <<< 3) + (e <<< 1) : e;
    endfunction : pae_scl

    // value range check shared by alarm value and both limits
    function automatic logic pae_bad_val(input logic [15:0] v);
        pae_bad_val = ($signed(v) < $signed(`PAE_VAL_MIN)) || ($signed(v) > $signed(`PAE_VAL_MAX));
    endfunction : pae_bad_val

    // the slave never stalls: read data and error are prepared in the setup cycle
    assign pready = 1'b1;
    assign prdata = st_r.prdata;
    assign pslverr = st_r.pslverr;
    assign alarm_out = st_r.out;

    // whole next state: sync, hold timer, bus slave, alarm evaluation
    always_comb begin
        logic [11:0] a;
        logic [1:0] ai;
        logic [1:0] bi;
        logic [1:0] vi;
        logic [1:0] wi;
        logic [31:0] rd;
        logic bad;
        logic werr;
        logic setup;
        logic wgo;
        logic is_cfg;
        logic is_val;
        logic lcan;
        logic srst;
        logic hold;
        logic ten;
        logic [NALM-1:0] rearm;
        logic signed [CW-1:0] pv;
        logic signed [CW-1:0] sp;
        logic signed [CW-1:0] hy;
        logic signed [CW-1:0] tu;
        logic signed [CW-1:0] tl;
        logic m_up;
        logic m_lo;
        logic m_rng;
        logic sb;
        logic nraw;
        logic ovl;
        logic func;
        logic state;
        logic [15:0] x;
        logic [15:0] hv;
        logic [15:0] lv;
        a = paddr;
        ai = paddr[3:2];
        bi = paddr[7:6];
        vi = paddr[5:4];
        wi = paddr[3:2];
        rd = '0;
        bad = 1'b0;
        werr = 1'b0;
        setup = psel & ~penable;
        wgo = psel & penable & pwrite & ~st_r.pslverr;
        is_cfg = (paddr[11:4] == `PAE_CFG_PAGE) && (int'(ai) < NALM);
        is_val = (paddr[11:8] == `PAE_VAL_PAGE) && (wi != `PAE_WORD_NONE)
                 && (int'(bi) < NBANK) && (int'(vi) < NALM);
        lcan = 1'b0;
        srst = 1'b0;
        rearm = '0;
        pv = '0;
        sp = '0;
        hy = '0;
        tu = '0;
        tl = '0;
        m_up = 1'b0;
        m_lo = 1'b0;
        m_rng = 1'b0;
        sb = 1'b0;
        nraw = 1'b0;
        ovl = 1'b0;
        func = 1'b0;
        state = 1'b0;
        x = '0;
        hv = '0;
        lv = '0;
        st_nxt = st_r;

        // power_ok passes two flops; only the second is read
        st_nxt.pok = {st_r.pok[0], power_ok};
        if (!st_r.pok[1]) begin
            st_nxt.hold_cnt = HCW'(HOLD_CYCLES);
        end else if (st_r.hold_cnt != '0) begin
            st_nxt.hold_cnt = st_r.hold_cnt - 1'b1;
        end
        hold = !st_r.pok[1] || (st_r.hold_cnt != '0);

        // address decode, read mux, write checks and write effects
        case (a)
            `PAE_OFS_CTRL: begin
                rd[`PAE_CTRL_RUN] = st_r.run;
                rd[`PAE_CTRL_DP_HI:`PAE_CTRL_DP_LO] = st_r.dp;
                if (wgo) begin
                    st_nxt.run = pwdata[`PAE_CTRL_RUN];
                    st_nxt.dp = pwdata[`PAE_CTRL_DP_HI:`PAE_CTRL_DP_LO];
                    if (pwdata[`PAE_CTRL_RUN] && !st_r.run) begin
                        rearm = '1;
                    end
                end
            end
            `PAE_OFS_CMD: begin
                if (wgo) begin
                    lcan = pwdata[`PAE_CMD_LCAN];
                    srst = pwdata[`PAE_CMD_SRST];
                end
            end
            `PAE_OFS_SETPT: begin
                rd = 32'(pae_ext(st_r.set_point));
                if (wgo) begin
                    st_nxt.set_point = pwdata[15:0];
                    if (pwdata[15:0] != st_r.set_point) begin
                        rearm = '1;
                    end
                end
            end
            `PAE_OFS_SHIFT: begin
                rd = 32'(pae_ext(st_r.in_shift));
                if (wgo) begin
                    st_nxt.in_shift = pwdata[15:0];
                    if (pwdata[15:0] != st_r.in_shift) begin
                        rearm = '1;
                    end
                end
            end
            `PAE_OFS_BANK: begin
                rd[1:0] = st_r.bank;
                werr = int'(pwdata[1:0]) >= NBANK;
                if (wgo) begin
                    st_nxt.bank = pwdata[1:0];
                    if (pwdata[1:0] != st_r.bank) begin
                        rearm = '1;
                    end
                end
            end
            `PAE_OFS_STAT: begin
                rd[`PAE_STAT_FUNC_LO +: NALM] = st_r.fst;
                rd[`PAE_STAT_OUT_LO +: NALM] = st_r.out;
                rd[`PAE_STAT_ARMED_LO +: NALM] = st_r.armed;
                rd[`PAE_STAT_HOLD] = hold;
                rd[`PAE_STAT_RUN] = st_r.run;
                werr = 1'b1; // read-only
            end
            default: begin
                if (is_cfg) begin
                    rd[`PAE_CFG_TYPE_HI:`PAE_CFG_TYPE_LO] = st_r.typ[ai];
                    rd[`PAE_CFG_LATCH] = st_r.latch_en[ai];
                    rd[`PAE_CFG_OPEN] = st_r.open_en[ai];
                    rd[`PAE_CFG_ASSIGN] = st_r.assigned[ai];
                    rd[`PAE_CFG_HYST_HI:`PAE_CFG_HYST_LO] = st_r.hyst[ai];
                    werr = (pwdata[`PAE_CFG_TYPE_HI:`PAE_CFG_TYPE_LO] > `PAE_TYPE_MAX)
                        || (pwdata[`PAE_CFG_HYST_HI:`PAE_CFG_HYST_LO] < `PAE_HYST_MIN)
                        || (pwdata[`PAE_CFG_HYST_HI:`PAE_CFG_HYST_LO] > `PAE_HYST_MAX);
                    if (st_r.run && ((pwdata[`PAE_CFG_LATCH] != st_r.latch_en[ai])
                        || (pwdata[`PAE_CFG_OPEN] != st_r.open_en[ai])
                        || (pwdata[`PAE_CFG_HYST_HI:`PAE_CFG_HYST_LO] != st_r.hyst[ai]))) begin
                        werr = 1'b1;
                    end
                    if (wgo) begin
                        st_nxt.typ[ai] = pwdata[`PAE_CFG_TYPE_HI:`PAE_CFG_TYPE_LO];
                        st_nxt.latch_en[ai] = pwdata[`PAE_CFG_LATCH];
                        st_nxt.open_en[ai] = pwdata[`PAE_CFG_OPEN];
                        st_nxt.assigned[ai] = pwdata[`PAE_CFG_ASSIGN];
                        st_nxt.hyst[ai] = pwdata[`PAE_CFG_HYST_HI:`PAE_CFG_HYST_LO];
                        if (pwdata[`PAE_CFG_TYPE_HI:`PAE_CFG_TYPE_LO] != st_r.typ[ai]) begin
                            rearm[ai] = 1'b1;
                        end
                    end
                end else if (is_val) begin
                    rd = 32'(pae_ext(st_r.val[bi][vi][wi]));
                    werr = pae_bad_val(pwdata[15:0]);
                    if (wgo) begin
                        st_nxt.val[bi][vi][wi] = pwdata[15:0];
                        if (bi == st_r.bank && pwdata[15:0] != st_r.val[bi][vi][wi]) begin
                            rearm[vi] = 1'b1;
                        end
                    end
                end else begin
                    bad = 1'b1;
                end
            end
        endcase
        // answer is staged at setup so it stands through the access cycle
        if (setup) begin
            st_nxt.pslverr = bad | (pwrite & werr);
            st_nxt.prdata = (pwrite || bad) ? '0 : rd;
        end
        // software reset re-arms every standby sequence
        if (srst) begin
            rearm = '1;
        end

        // scale to tenths when decimal point is 0
        ten = (st_r.dp == `PAE_RST_DP);
        pv = pae_scl(pae_ext(process_value) + pae_ext(st_r.in_shift), ten);
        sp = pae_scl(pae_ext(st_r.set_point), ten);

        for (int i = 0; i < NALM; i++) begin
            x = st_r.val[st_r.bank][i][`PAE_WORD_X];
            hv = st_r.val[st_r.bank][i][`PAE_WORD_HI];
            lv = st_r.val[st_r.bank][i][`PAE_WORD_LO];
            hy = CW'($signed({1'b0, st_r.hyst[i]}));
            tu = '0;
            tl = '0;
            m_up = 1'b0;
            m_lo = 1'b0;
            m_rng = 1'b0;
            sb = 1'b0;
            case (pae_type_e'(st_r.typ[i]))
                PAE_T_UL, PAE_T_UL_SB: begin
                    tu = sp + pae_scl(pae_ext(hv), ten);
                    tl = sp - pae_scl(pae_ext(lv), ten);
                    m_up = 1'b1;
                    m_lo = 1'b1;
                    sb = (st_r.typ[i] == PAE_T_UL_SB);
                end
                PAE_T_RNG: begin
                    tu = sp + pae_scl(pae_ext(hv), ten);
                    tl = sp - pae_scl(pae_ext(lv), ten);
                    m_rng = 1'b1;
                end
                PAE_T_UP, PAE_T_UP_SB: begin
                    tu = sp + pae_scl(pae_ext(x), ten);
                    m_up = 1'b1;
                    sb = (st_r.typ[i] == PAE_T_UP_SB);
                end
                PAE_T_LO, PAE_T_LO_SB: begin
                    tl = sp - pae_scl(pae_ext(x), ten);
                    m_lo = 1'b1;
                    sb = (st_r.typ[i] == PAE_T_LO_SB);
                end
                PAE_T_AUP, PAE_T_AUP_SB: begin
                    tu = pae_scl(pae_ext(x), ten);
                    m_up = 1'b1;
                    sb = (st_r.typ[i] == PAE_T_AUP_SB);
                end
                PAE_T_ALO, PAE_T_ALO_SB: begin
                    tl = pae_scl(pae_ext(x), ten);
                    m_lo = 1'b1;
                    sb = (st_r.typ[i] == PAE_T_ALO_SB);
                end
                default: begin
                    // off and loop burnout: no level compare here
                    m_up = 1'b0;
                end
            endcase
            // on at threshold, off once back past threshold by more than the hysteresis
            nraw = (m_up && (st_r.raw[i] ? pv >= tu - hy : pv >= tu))
                || (m_lo && (st_r.raw[i] ? pv <= tl + hy : pv <= tl))
                || (m_rng && (st_r.raw[i] ? (pv <= tu + hy && pv >= tl - hy)
                                         : (pv <= tu && pv >= tl)));
            // overlapping hysteresis bands force the alarm off
            ovl = ((m_up && m_lo) || m_rng) && (tu - hy <= tl + hy);
            func = nraw && !ovl && !(sb && st_r.armed[i]);
            st_nxt.raw[i] = nraw;
            // leaving the range disarms; a re-arm in the same cycle wins
            if (rearm[i]) begin
                st_nxt.armed[i] = 1'b1;
            end else if (!nraw) begin
                st_nxt.armed[i] = 1'b0;
            end
            // latch: set wins over cancel, type 0 clears it
            st_nxt.latched[i] = (st_r.typ[i] != PAE_T_OFF)
                && ((st_r.latch_en[i] && func) || (st_r.latched[i] && !(lcan || srst)));
            state = func || (st_r.latched[i] && (st_r.typ[i] != PAE_T_OFF));
            st_nxt.fst[i] = state;
            // hold open; polarity only when assigned
            if (hold) begin
                st_nxt.out[i] = 1'b0;
            end else begin
                st_nxt.out[i] = (st_r.assigned[i] && st_r.open_en[i]) ? !state : state;
            end
        end
    end

    // single state register; standby armed from power-on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.hold_cnt <= HCW'(HOLD_CYCLES);
            st_r.dp <= `PAE_RST_DP;
            st_r.typ <= {NALM{`PAE_RST_TYPE}};
            st_r.hyst <= {NALM{`PAE_RST_HYST}};
            st_r.armed <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : pae_evaluator

// ==== shared/pae_regs.svh ====
// register map, field positions, reset values, limits and timing of the alarm evaluator
// assumes a 12-bit APB byte address and 32-bit data; included by bare name
`ifndef PAE_REGS_SVH
`define PAE_REGS_SVH
// byte offsets of the fixed registers
`define PAE_OFS_CTRL 12'h000
`define PAE_OFS_CMD 12'h004
`define PAE_OFS_SETPT 12'h008
`define PAE_OFS_SHIFT 12'h00c
`define PAE_OFS_BANK 12'h010
`define PAE_OFS_STAT 12'h014
// per-alarm config words: paddr[11:4] page, paddr[3:2] alarm index
`define PAE_CFG_PAGE 8'h02
// banked values: paddr[11:8] page, [7:6] bank, [5:4] alarm, [3:2] word
`define PAE_VAL_PAGE 4'h1
`define PAE_WORD_X 2'h0
`define PAE_WORD_HI 2'h1
`define PAE_WORD_LO 2'h2
`define PAE_WORD_NONE 2'h3
// control and command bits
`define PAE_CTRL_RUN 0
`define PAE_CTRL_DP_LO 4
`define PAE_CTRL_DP_HI 5
`define PAE_CMD_LCAN 0
`define PAE_CMD_SRST 1
// config word fields
`define PAE_CFG_TYPE_HI 3
`define PAE_CFG_TYPE_LO 0
`define PAE_CFG_LATCH 4
`define PAE_CFG_OPEN 5
`define PAE_CFG_ASSIGN 6
`define PAE_CFG_HYST_HI 29
`define PAE_CFG_HYST_LO 16
// status fields, one nibble per alarm group; hold and run share the fourth nibble
`define PAE_STAT_FUNC_LO 0
`define PAE_STAT_OUT_LO 4
`define PAE_STAT_ARMED_LO 8
`define PAE_STAT_HOLD 12
`define PAE_STAT_RUN 13
// reset values and accepted ranges
`define PAE_RST_TYPE 4'h2
`define PAE_RST_HYST 14'h0002
`define PAE_RST_DP 2'h0
`define PAE_TYPE_MAX 4'hc
`define PAE_VAL_MIN 16'hf831
`define PAE_VAL_MAX 16'h270f
`define PAE_HYST_MIN 14'h0001
`define PAE_HYST_MAX 14'h2708
// output hold after power-up
`define PAE_HOLD_TIME_MS 3000
`define PAE_CLK_KHZ 25000
`endif

// ==== shared/pae_pkg.sv ====
// types shared by the alarm evaluator
// assumes nothing beyond a SystemVerilog compiler
package pae_pkg;
    // alarm function codes held in the type field
    typedef enum logic [3:0] {
        PAE_T_OFF = 4'h0,
        PAE_T_UL = 4'h1,
        PAE_T_UP = 4'h2,
        PAE_T_LO = 4'h3,
        PAE_T_RNG = 4'h4,
        PAE_T_UL_SB = 4'h5,
        PAE_T_UP_SB = 4'h6,
        PAE_T_LO_SB = 4'h7,
        PAE_T_AUP = 4'h8,
        PAE_T_ALO = 4'h9,
        PAE_T_AUP_SB = 4'ha,
        PAE_T_ALO_SB = 4'hb,
        PAE_T_LBA = 4'hc
    } pae_type_e;
endpackage : pae_pkg

// ==== bench/pae_evaluator_assertions.sv ====
// port-level checks on the alarm evaluator: APB refusals, output hold, output causes
// assumes pae_regs.svh on the include path; bound to every pae_evaluator instance
`timescale 1ns/100ps
`include "pae_regs.svh"
module pae_evaluator_assertions #(
    parameter int NALM = 3,
    parameter int HOLD_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] process_value,
    input wire logic power_ok,
    input wire logic [NALM-1:0] alarm_out
);
    logic [31:0] up_r;
    logic [31:0] up_nxt;
    logic [1:0] pk_r;
    logic acc;
    logic wr_cfg;
    logic wr_val;
    logic signed [15:0] wval;
    // decoded access and setup cycles; refusals are judged on the staged answer
    assign acc = psel && penable;
    assign wr_cfg = psel && !penable && pwrite && paddr[11:4] == `PAE_CFG_PAGE;
    assign wr_val = psel && !penable && pwrite && paddr[11:8] == `PAE_VAL_PAGE
        && paddr[3:2] != `PAE_WORD_NONE;
    assign wval = pwdata[15:0];
    // supply seen through the same two-flop delay as the design, so the
    // count restarts on the edge at which the design can first react
    always_ff @(posedge clk or posedge rst) begin
        if (rst) pk_r <= '0;
        else pk_r <= {pk_r[0], power_ok};
    end
    // cycles since reset or power loss; saturates so it never wraps
    always_comb begin
        up_nxt = up_r;
        if (!pk_r[1]) up_nxt = '0;
        else if (up_r < 32'(HOLD_CYCLES + 8)) up_nxt = up_r + 32'h1;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) up_r <= '0;
        else up_r <= up_nxt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_power_gone;
        !power_ok [*6];
    endsequence
    sequence s_bad_type;
        wr_cfg && pwdata[3:0] > `PAE_TYPE_MAX;
    endsequence
    sequence s_bad_hyst;
        wr_cfg && (pwdata[29:16] == 14'h0 || pwdata[29:16] > `PAE_HYST_MAX);
    endsequence
    sequence s_bad_value;
        wr_val && (wval < $signed(`PAE_VAL_MIN) || wval > $signed(`PAE_VAL_MAX));
    endsequence
    a_ready_high: assert property (pready)
        else $error("pready dropped");
    a_hold_open: assert property (up_r < HOLD_CYCLES |-> alarm_out == '0)
        else $error("output closed during power-up hold");
    a_power_loss: assert property (s_power_gone |-> alarm_out == '0)
        else $error("output closed without power");
    a_type_refused: assert property (s_bad_type |=> pslverr)
        else $error("bad type accepted");
    a_hyst_refused: assert property (s_bad_hyst |=> pslverr)
        else $error("bad hysteresis accepted");
    a_value_refused: assert property (s_bad_value |=> pslverr)
        else $error("bad alarm value accepted");
    a_hole_read: assert property (psel && !penable && !pwrite && paddr == 12'h018
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_out_has_cause: assert property (
        $changed(alarm_out) && up_r > HOLD_CYCLES + 6
        |-> $past(process_value) != $past(process_value, 2) || $past(acc) || $past(acc, 2))
        else $error("output moved without cause");
endmodule : pae_evaluator_assertions
bind pae_evaluator pae_evaluator_assertions #(.NALM(NALM), .HOLD_CYCLES(HOLD_CYCLES)) u_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .process_value(process_value), .power_ok(power_ok), .alarm_out(alarm_out));

// ==== bench/pae_contact.sv ====
// relay contacts behind the alarm outputs
// assumes alarm_out high energises a coil and power_ok high means supply present
`timescale 1ns/100ps
module pae_contact #(
    parameter int NALM = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [NALM-1:0] alarm_out,
    input wire logic power_ok,
    output logic [NALM-1:0] contact_closed
);
    // open without supply
    // one clock of pull-in delay; a coil drops out with its supply
    always_ff @(posedge clk or posedge rst) begin
        if (rst) contact_closed <= '0;
        else contact_closed <= power_ok ? alarm_out : '0;
    end
endmodule : pae_contact

// ==== bench/pae_evaluator_tb.sv ====
// self-checking bench for the alarm evaluator: APB host, process value, supply
// assumes the design, its package and pae_contact compiled before it
`timescale 1ns/100ps
`define PAE_CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch t=%0t got %h exp %h", $time, got, exp); end end
module pae_evaluator_tb;
    import pae_pkg::*;
    localparam int HOLD = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] pv = 16'h0;
    logic power_ok = 1'b1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] alarm_out;
    logic [2:0] contact_closed;
    logic [31:0] rd;
    logic er;
    logic [15:0] rv;
    int error_cnt = 0;
    int compares = 0;
    int i;
    // walks: process values and expected function of alarm 0
    int wv [5] = '{110, 109, 107, 109, 110};
    logic we [5] = '{1, 1, 0, 0, 1};
    int sv [4] = '{95, 50, 95, 50};
    logic se [4] = '{0, 1, 0, 1};
    logic [3:0] tt [11] = '{4'h1, 4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'h3};
    int tp [11] = '{115, 100, 100, 500, 500, 105, 500, 500, 0, 500, 85};
    logic te [11] = '{1, 0, 1, 0, 0, 1, 0, 0, 0, 0, 1};
    logic [11:0] ra [5] = '{12'h020, 12'h020, 12'h020, 12'h104, 12'h100};
    logic [31:0] rdat [5] = '{32'h0002000d, 32'h00000002, 32'h27090002, 32'd10000, 32'hf830};
    pae_evaluator #(.NALM(3), .NBANK(4), .HOLD_CYCLES(HOLD)) DUT (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .process_value(pv), .power_ok(power_ok), .alarm_out(alarm_out));
    pae_contact #(.NALM(3)) u_contact (.clk(clk), .rst(rst), .alarm_out(alarm_out),
        .power_ok(power_ok), .contact_closed(contact_closed));
    always #20 clk = ~clk;
    // config word from type, {assign, open, latch} and raw hysteresis
    function automatic logic [31:0] cfg(input logic [3:0] t, input logic [2:0] f,
        input logic [13:0] h);
        cfg = {2'h0, h, 9'h0, f, t};
    endfunction : cfg
    function automatic logic f_abs_up(input logic signed [15:0] v);
        f_abs_up = v >= 16'sd50;
    endfunction : f_abs_up
    // one APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // settle three edges, then compare the masked outputs
    task chk(input logic [2:0] m, input logic [2:0] e);
        repeat (3) @(posedge clk);
        #1;
        `PAE_CHK(alarm_out & m, e)
    endtask : chk
    task step(input int v, input logic [2:0] m, input logic [2:0] e);
        @(posedge clk);
        pv <= 16'(v);
        chk(m, e);
    endtask : step
    task results;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    // watchdog: the whole sequence needs about five hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results;
    end
    initial begin
        void'($urandom(32'h03cedec1));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        step(500, 3'h7, 3'h0);
        repeat (HOLD) @(posedge clk);
        apb(0, 12'h020, 0);
        `PAE_CHK(rd, cfg(PAE_T_UP, 3'h0, 14'h2))
        apb(0, 12'h100, 0);
        `PAE_CHK(rd, 32'h0)
        // dp 1 keeps hysteresis in whole units; alarms 1 and 2 differ in type
        apb(1, 12'h000, 32'h10);
        apb(1, 12'h024, cfg(PAE_T_OFF, 3'h0, 14'h2));
        apb(1, 12'h028, cfg(PAE_T_LO, 3'h0, 14'h2));
        step(500, 3'h7, 3'h1);
        step(-5, 3'h7, 3'h4);
        apb(1, 12'h008, 32'd100);
        apb(1, 12'h100, 32'd10);
        for (i = 0; i < 5; i++) step(wv[i], 3'h1, {2'h0, we[i]});
        apb(1, 12'h000, 32'h0);
        step(109, 3'h1, 3'h0);
        apb(1, 12'h000, 32'h10);
        apb(1, 12'h020, cfg(PAE_T_UP, 3'h2, 14'h2));
        chk(3'h1, 3'h0);
        apb(1, 12'h020, cfg(PAE_T_UP, 3'h6, 14'h2));
        chk(3'h1, 3'h1);
        step(110, 3'h1, 3'h0);
        // latch released by cancel, then by software reset
        apb(1, 12'h020, cfg(PAE_T_UP, 3'h1, 14'h2));
        step(0, 3'h1, 3'h1);
        apb(1, 12'h004, 32'h1);
        chk(3'h1, 3'h0);
        step(110, 3'h1, 3'h1);
        step(0, 3'h1, 3'h1);
        apb(1, 12'h004, 32'h2);
        chk(3'h1, 3'h0);
        apb(1, 12'h020, cfg(PAE_T_OFF, 3'h1, 14'h2));
        step(500, 3'h1, 3'h0);
        step(50, 3'h1, 3'h0);
        // standby lower alarm entered from inside its range
        apb(1, 12'h020, cfg(PAE_T_LO_SB, 3'h0, 14'h2));
        chk(3'h1, 3'h0);
        for (i = 0; i < 4; i++) step(sv[i], 3'h1, {2'h0, se[i]});
        apb(1, 12'h008, 32'd101);
        chk(3'h1, 3'h0);
        // shift and bank changes re-arm a standby that had been left
        step(95, 3'h1, 3'h0);
        step(50, 3'h1, 3'h1);
        apb(1, 12'h00c, 32'h1);
        chk(3'h1, 3'h0);
        step(95, 3'h1, 3'h0);
        step(50, 3'h1, 3'h1);
        apb(1, 12'h010, 32'h1);
        chk(3'h1, 3'h0);
        apb(1, 12'h010, 32'h0);
        apb(1, 12'h00c, 32'h0);
        // type codes other than 0, 2 and 7; limits 10 either side of a set point of 100
        apb(1, 12'h008, 32'd100);
        apb(1, 12'h104, 32'd10);
        apb(1, 12'h108, 32'd10);
        for (i = 0; i < 11; i++) begin
            @(posedge clk);
            pv <= 16'(tp[i]);
            apb(1, 12'h020, cfg(tt[i], 3'h0, 14'h2));
            chk(3'h1, {2'h0, te[i]});
        end
        apb(1, 12'h104, 32'd1);
        apb(1, 12'h108, 32'd1);
        apb(1, 12'h020, cfg(PAE_T_UL, 3'h0, 14'h2));
        step(500, 3'h1, 3'h0);
        apb(1, 12'h000, 32'h11);
        apb(1, 12'h020, cfg(PAE_T_UL, 3'h0, 14'h5));
        `PAE_CHK(er, 1'b1)
        apb(1, 12'h000, 32'h10);
        for (i = 0; i < 5; i++) begin
            apb(1, ra[i], rdat[i]);
            `PAE_CHK(er, 1'b1)
        end
        apb(0, 12'h018, 0);
        `PAE_CHK({er, rd}, {1'b1, 32'h0})
        // supply loss opens everything, then the hold runs again
        apb(1, 12'h020, cfg(PAE_T_AUP, 3'h0, 14'h2));
        `PAE_CHK(er, 1'b0)
        step(500, 3'h1, 3'h1);
        @(posedge clk);
        power_ok <= 1'b0;
        repeat (3) @(posedge clk);
        chk(3'h7, 3'h0);
        `PAE_CHK(contact_closed, 3'h0)
        @(posedge clk);
        power_ok <= 1'b1;
        repeat (HOLD + 5) @(posedge clk);
        chk(3'h1, 3'h1);
        for (i = 0; i < 8; i++) begin
            rv = 16'($urandom_range(11998)) - 16'd1999;
            apb(1, 12'h110, {16'($urandom), rv});
            apb(0, 12'h110, 0);
            `PAE_CHK(rd, {{16{rv[15]}}, rv})
        end
        apb(1, 12'h100, 32'd50);
        for (i = 0; i < 20; i++) begin
            rv = 16'($urandom_range(600)) - 16'd300;
            if (rv == 16'd48 || rv == 16'd49) rv = 16'd100;
            step(int'($signed(rv)), 3'h1, {2'h0, f_abs_up(rv)});
        end
        results;
    end
endmodule : pae_evaluator_tb
